// ===== core/twr_pkg.sv
// Package: register map, status codes and carrier structs for the two-wire register block
package twr_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index
	localparam int IDX_SHIFT = 2; // Index to byte address shift
	localparam logic [7:0] IDX_RATE = 8'hB8; // Bit-rate divisor
	localparam logic [7:0] IDX_STAT = 8'hB9; // bus_status_and_prescale
	localparam logic [7:0] IDX_ADDR = 8'hBA; // own_slave_address
	localparam logic [7:0] IDX_DATA = 8'hBB; // serial_data_byte
	localparam logic [7:0] IDX_CTRL = 8'hBC; // Flag and acknowledge control
	localparam logic [7:0] IDX_MASK = 8'hBD; // slave_address_mask
	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [1:0] RST_PS = 2'h0;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [7:0] RST_DATA = 8'hFF;
	localparam logic [7:0] RST_MASK = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CODE_LSB = 3; // Status code sits in bits 7:3
	localparam int CTRL_FLAG = 7; // job_complete_flag, write one to clear
	localparam int CTRL_ACK = 6; // ack_generate_enable
	localparam int GCE_BIT = 0; // general_call_accept
	////////////////////////////////////////////////////////////////////////
	// Status codes as full bytes
	localparam logic [7:0] C_BUS_ERR = 8'h00, C_START = 8'h08, C_RSTART = 8'h10;
	localparam logic [7:0] C_MT_SLA_ACK = 8'h18, C_MT_SLA_NACK = 8'h20;
	localparam logic [7:0] C_MT_DAT_ACK = 8'h28, C_MT_DAT_NACK = 8'h30, C_ARB_LOST = 8'h38;
	localparam logic [7:0] C_MR_SLA_ACK = 8'h40, C_MR_SLA_NACK = 8'h48;
	localparam logic [7:0] C_MR_DAT_ACK = 8'h50, C_MR_DAT_NACK = 8'h58;
	localparam logic [7:0] C_SR_SLA = 8'h60, C_SR_SLA_ARB = 8'h68, C_SR_GC = 8'h70, C_SR_GC_ARB = 8'h78;
	localparam logic [7:0] C_SR_DAT_ACK = 8'h80, C_SR_DAT_NACK = 8'h88;
	localparam logic [7:0] C_GC_DAT_ACK = 8'h90, C_GC_DAT_NACK = 8'h98, C_SR_STOP = 8'hA0;
	localparam logic [7:0] C_ST_SLA = 8'hA8, C_ST_SLA_ARB = 8'hB0, C_ST_DAT_ACK = 8'hB8;
	localparam logic [7:0] C_ST_DAT_NACK = 8'hC0, C_ST_LAST_ACK = 8'hC8, C_IDLE = 8'hF8;
	////////////////////////////////////////////////////////////////////////
	// Bit-rate period = RATE_BASE + 2 * divisor * 4^prescale
	localparam logic [15:0] RATE_BASE = 16'h0010;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	////////////////////////////////////////////////////////////////////////
	// Carriers between this block and the bus engine
	typedef struct packed {
		logic valid; // One-cycle step completion
		logic [4:0] code; // Status code of the step
	} twr_evt_s;
	typedef struct packed {
		logic valid; // One sampled bus bit
		logic value; // Its level
	} twr_bit_s;
	typedef struct packed {
		logic valid; // Address byte complete
		logic [7:0] byte_v; // Address and direction bit
	} twr_adr_s;
	typedef struct packed {
		logic scl_hold; // Hold serial clock low
		logic ack_en; // Acknowledge generation enabled
		logic resume; // One-cycle pulse when software restarts
		logic bit_tick; // Master bit-rate tick
		logic [7:0] tx_byte; // Byte to shift out
	} twr_eng_s;
endpackage

// ===== core/twr_regs.sv
// Register file, status latch, data shifter and address comparator of the two-wire unit
// Functional notes
// - Status code occupies bits 7:3 of status
// - Code 0x00 marks illegal START/STOP bus error
// - Master START gives 0x08, repeated START 0x10
// - Master transmit address/data acks give 0x18-0x30
// - Lost arbitration gives 0x38
// - Master read address ack/nack gives 0x40/0x48
// - Master received data ack/nack gives 0x50/0x58
// - Slave own/general address gives 0x60-0x78
// - Slave received data gives 0x80-0x98
// - STOP or restart while addressed gives 0xA0
// - Slave read address gives 0xA8 or 0xB0
// - Slave sent byte gives 0xB8, 0xC0, 0xC8
// - Code 0xF8 whenever completion flag is clear
// - Status bit 2, mask bit 0 read zero
// - Prescaler bits 1:0 select 1, 4, 16, 64
// - Data byte holds next/last byte, resets ones
// - Data writes only while completion flag set
// - Data byte stable while completion flag set
// - Bus bits shift in; none lost on arbitration
// - Acknowledge bit handled purely by hardware
// - Compare received address with own bits 7:1
// - General call accepted only when enable set; own compare also matches 0x00 if unmasked own bits 7:1 are zero
// - Set mask bits exclude address bits
// - Flag set on step, holds clock, W1C
// - Master clock period from divisor and prescale
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module twr_regs
	import twr_pkg::*;
#(
	parameter int ADDR_W = 12 // AXI byte address width
) (
	input wire logic aclk, // System clock, 25 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire twr_evt_s step_evt, // Bus step finished
	input wire twr_bit_s rx_bit, // Bit sampled from the bus
	input wire twr_adr_s addr_byte, // Received address byte
	input wire logic master_active, // Engine is driving the clock
	output twr_eng_s eng, // Controls back to the engine
	output logic addr_match // Pulse: address recognised
);
	localparam int IW = ADDR_W - IDX_SHIFT; // Index width
	// Refused at elaboration: the index field must hold every register index
	if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must cover the register indices");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	logic aw_full_q, aw_full_d; // Write address held
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d; // Held write address
	logic w_full_q, w_full_d; // Write data held
	logic [31:0] w_data_q, w_data_d; // Held write data
	logic w_lane_q, w_lane_d; // Held strobe of byte lane 0
	logic bvalid_q, bvalid_d; // Write response pending
	logic [1:0] bresp_q, bresp_d; // Write response code
	logic rvalid_q, rvalid_d; // Read data pending
	logic [31:0] rdata_q, rdata_d; // Read data
	logic [1:0] rresp_q, rresp_d; // Read response code
	logic [7:0] rate_q, rate_d; // bit_rate_divisor
	logic [1:0] ps_q, ps_d; // rate_prescale_sel
	logic [7:0] own_q, own_d; // own_slave_address
	logic [7:0] mask_q, mask_d; // slave_address_mask
	logic [7:0] data_q, data_d; // serial_data_byte
	logic flag_q, flag_d; // job_complete_flag
	logic ack_q, ack_d; // ack_generate_enable
	logic [4:0] code_q, code_d; // bus_state_code
	logic match_q, match_d; // Address match pulse
	logic resume_q, resume_d; // Restart pulse
	logic [15:0] cnt_q, cnt_d; // Bit-rate counter
	logic tick_q, tick_d; // Bit-rate tick
	////////////////////////////////////////////////////////////////////////
	// Combinational helpers
	logic do_write; // Both write halves present
	logic wr_lane; // Write carries byte lane 0
	logic evt_set; // Step accepted this cycle
	logic flag_clr; // Software writes one to the flag
	logic data_try; // Software write to the data byte
	logic [7:0] stat_view; // Status as software reads it
	logic [6:0] cmp_diff; // Unmasked mismatching bits
	logic own_hit; // Own address matches
	logic gc_hit; // General call recognised
	logic [15:0] period; // Bit-rate period in cycles

	// Index compare; the two low byte-address bits are ignored
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a[ADDR_W-1:IDX_SHIFT] == IW'(idx));
	endfunction

	// Unknown codes from the engine degrade to the bus-error code
	function automatic logic [4:0] legal_code(input logic [4:0] c);
		logic [7:0] b;
		b = {c, 3'h0};
		case (b)
			C_BUS_ERR: legal_code = c;
			C_START, C_RSTART: legal_code = c;
			C_MT_SLA_ACK, C_MT_SLA_NACK, C_MT_DAT_ACK, C_MT_DAT_NACK: legal_code = c;
			C_ARB_LOST: legal_code = c;
			C_MR_SLA_ACK, C_MR_SLA_NACK: legal_code = c;
			C_MR_DAT_ACK, C_MR_DAT_NACK: legal_code = c;
			C_SR_SLA, C_SR_SLA_ARB, C_SR_GC, C_SR_GC_ARB: legal_code = c;
			C_SR_DAT_ACK, C_SR_DAT_NACK, C_GC_DAT_ACK, C_GC_DAT_NACK: legal_code = c;
			C_SR_STOP: legal_code = c;
			C_ST_SLA, C_ST_SLA_ARB: legal_code = c;
			C_ST_DAT_ACK, C_ST_DAT_NACK, C_ST_LAST_ACK: legal_code = c;
			default: legal_code = C_BUS_ERR[7:CODE_LSB];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decode of the flag, data and status views
	always_comb begin
		do_write = aw_full_q && w_full_q && !bvalid_q;
		wr_lane = do_write && w_lane_q;
		flag_clr = wr_lane && hit(aw_addr_q, IDX_CTRL) && w_data_q[CTRL_FLAG];
		// A step that meets a clear in the same cycle is kept
		evt_set = step_evt.valid && (!flag_q || flag_clr);
		data_try = wr_lane && hit(aw_addr_q, IDX_DATA);
		// Reads show the idle code while no step is pending
		stat_view = {flag_q ? code_q : C_IDLE[7:CODE_LSB], 1'b0, ps_q};
		cmp_diff = (addr_byte.byte_v[7:1] ^ own_q[7:1]) & ~mask_q[7:1];
		own_hit = (cmp_diff == 7'h00);
		gc_hit = (addr_byte.byte_v[7:1] == C_BUS_ERR[7:1]) && own_q[GCE_BIT];
		// Divisor term grows by four per prescale step: shift by 2*sel
		period = RATE_BASE + (16'({rate_q, 1'b0}) << {ps_q, 1'b0});
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite channels: next values
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_lane_d = w_lane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		// Address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_lane_d = s_axi_wstrb[0];
		end
		// Register update happens here; answer on the next edge
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_SLVERR;
			if (hit(aw_addr_q, IDX_RATE) || hit(aw_addr_q, IDX_STAT) || hit(aw_addr_q, IDX_ADDR) ||
				hit(aw_addr_q, IDX_DATA) || hit(aw_addr_q, IDX_CTRL) || hit(aw_addr_q, IDX_MASK)) begin
				bresp_d = RESP_OKAY;
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// Reads answer one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (hit(s_axi_araddr, IDX_RATE)) begin
				rdata_d[7:0] = rate_q;
			end else if (hit(s_axi_araddr, IDX_STAT)) begin
				rdata_d[7:0] = stat_view;
			end else if (hit(s_axi_araddr, IDX_ADDR)) begin
				rdata_d[7:0] = own_q;
			end else if (hit(s_axi_araddr, IDX_DATA)) begin
				rdata_d[7:0] = data_q;
			end else if (hit(s_axi_araddr, IDX_CTRL)) begin
				// Acknowledge bit of the bus itself is never visible
				rdata_d[CTRL_FLAG] = flag_q;
				rdata_d[CTRL_ACK] = ack_q;
			end else if (hit(s_axi_araddr, IDX_MASK)) begin
				rdata_d[7:0] = mask_q;
			end else begin
				rresp_d = RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers, flag, data shifter, comparator and bit rate: next values
	always_comb begin
		rate_d = rate_q;
		ps_d = ps_q;
		own_d = own_q;
		mask_d = mask_q;
		ack_d = ack_q;
		data_d = data_q;
		code_d = code_q;
		if (wr_lane && hit(aw_addr_q, IDX_RATE)) begin
			rate_d = w_data_q[7:0];
		end
		// Only the prescale bits are writable; code and bit 2 ignore writes
		if (wr_lane && hit(aw_addr_q, IDX_STAT)) begin
			ps_d = w_data_q[1:0];
		end
		if (wr_lane && hit(aw_addr_q, IDX_ADDR)) begin
			own_d = w_data_q[7:0];
		end
		if (wr_lane && hit(aw_addr_q, IDX_MASK)) begin
			mask_d = {w_data_q[7:1], 1'b0};
		end
		if (wr_lane && hit(aw_addr_q, IDX_CTRL)) begin
			ack_d = w_data_q[CTRL_ACK];
		end
		// Software may write only while no byte is shifting
		if (data_try && flag_q) begin
			data_d = w_data_q[7:0];
		end else if (!flag_q && rx_bit.valid) begin
			// Shifting continues across a lost arbitration
			data_d = {data_q[6:0], rx_bit.value};
		end
		// Code changes only together with the flag
		if (evt_set) begin
			code_d = legal_code(step_evt.code);
		end
		flag_d = evt_set || (flag_q && !flag_clr);
		resume_d = flag_q && flag_clr && !evt_set;
		match_d = addr_byte.valid && (own_hit || gc_hit);
		// The counter is held at zero while the clock is stretched
		cnt_d = 16'h0000;
		tick_d = 1'b0;
		if (master_active && !flag_q) begin
			if (cnt_q >= period - 16'h0001) begin
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registering
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_lane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
			rate_q <= RST_RATE;
			ps_q <= RST_PS;
			own_q <= RST_ADDR;
			mask_q <= RST_MASK;
			data_q <= RST_DATA;
			flag_q <= 1'b0;
			ack_q <= 1'b0;
			code_q <= C_IDLE[7:CODE_LSB];
			match_q <= 1'b0;
			resume_q <= 1'b0;
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_lane_q <= w_lane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			rate_q <= rate_d;
			ps_q <= ps_d;
			own_q <= own_d;
			mask_q <= mask_d;
			data_q <= data_d;
			flag_q <= flag_d;
			ack_q <= ack_d;
			code_q <= code_d;
			match_q <= match_d;
			resume_q <= resume_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign eng = '{scl_hold: flag_q, ack_en: ack_q, resume: resume_q, bit_tick: tick_q, tx_byte: data_q};
	assign addr_match = match_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_flag_sets: assert property (step_evt.valid && !flag_q |=> flag_q && eng.scl_hold)
		else $error("flag not set after a step");
	chk_set_wins: assert property (step_evt.valid && flag_clr |=> flag_q && !resume_q)
		else $error("step lost against a clear");
	chk_idle_code: assert property (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, IDX_STAT) && !flag_q
		|=> s_axi_rdata[7:CODE_LSB] == C_IDLE[7:CODE_LSB])
		else $error("idle code missing while flag clear");
	chk_code_hold: assert property (flag_q && !evt_set |=> $stable(code_q))
		else $error("status code moved while flag set");
	chk_data_stable: assert property (flag_q && !data_try |=> $stable(data_q))
		else $error("data byte moved while flag set");
	chk_data_block: assert property (!flag_q && data_try && !rx_bit.valid |=> $stable(data_q))
		else $error("data written while shifting");
	chk_resv_zero: assert property (stat_view[2] == 1'b0 && mask_q[0] == 1'b0)
		else $error("reserved bit not zero");
	chk_gc_ignore: assert property (addr_byte.valid && !own_q[GCE_BIT] && own_hit == 1'b0 |=> !addr_match)
		else $error("address matched without cause");
	chk_own_match: assert property (addr_byte.valid && own_hit |=> addr_match)
		else $error("own address not matched");
	chk_ps_write: assert property (wr_lane && hit(aw_addr_q, IDX_STAT) |=> ps_q == $past(w_data_q[1:0]))
		else $error("prescale bits not written");
	cov_step_clear: cover property (flag_q && flag_clr ##1 !flag_q);
	cov_gc_match: cover property (addr_byte.valid && gc_hit);
	cov_tick: cover property (tick_q);
	cov_set_wins: cover property (step_evt.valid && flag_clr);
endmodule

// ===== verif/twr_eng_model.sv
// Bus-engine stand-in that feeds step events, sampled bits and address bytes to the register block
`timescale 1ns/100ps
module twr_eng_model
	import twr_pkg::*;
(
	input wire logic aclk, // System clock
	output twr_evt_s step_evt, // Step completion events
	output twr_bit_s rx_bit, // Sampled bus bits
	output twr_adr_s addr_byte // Received address bytes
);
	////////////////////////////////////////////////////////////////////////
	// Idle payloads are inverted after use, so a stale value never passes for fresh data
	initial begin
		step_evt = '{valid: 1'b0, code: 5'h15};
		rx_bit = '{valid: 1'b0, value: 1'b1};
		addr_byte = '{valid: 1'b0, byte_v: 8'hA5};
	end
	// One-cycle step event; the caller stands just past a rising edge
	task automatic step(input logic [7:0] c);
		step_evt <= '{valid: 1'b1, code: c[7:3]};
		@(posedge aclk);
		step_evt <= '{valid: 1'b0, code: ~c[7:3]};
	endtask
	// Eight bus bits, most significant first, one per cycle
	task automatic shift(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			rx_bit <= '{valid: 1'b1, value: b[i]};
			@(posedge aclk);
		end
		rx_bit <= '{valid: 1'b0, value: ~b[0]};
	endtask
	// Complete address byte with direction bit
	task automatic adr(input logic [7:0] b);
		addr_byte <= '{valid: 1'b1, byte_v: b};
		@(posedge aclk);
		addr_byte <= '{valid: 1'b0, byte_v: ~b};
	endtask
endmodule

// ===== verif/two_wire_status_addr_regs_test.sv
// Self-checking testbench for the two-wire status, data and address register block
`timescale 1ns/100ps
module two_wire_status_addr_regs_test;
	import twr_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// Byte addresses on the register bus
	localparam logic [11:0] A_RATE = 12'({IDX_RATE, 2'b00}), A_STAT = 12'({IDX_STAT, 2'b00});
	localparam logic [11:0] A_ADDR = 12'({IDX_ADDR, 2'b00}), A_DATA = 12'({IDX_DATA, 2'b00});
	localparam logic [11:0] A_CTRL = 12'({IDX_CTRL, 2'b00}), A_MASK = 12'({IDX_MASK, 2'b00});
	logic aclk = 1'b0, aresetn = 1'b0, master_active = 1'b0; // Clock, reset, engine activity
	logic [11:0] awaddr = 12'h000, araddr = 12'h000; // Bus addresses
	logic [31:0] wdata = 32'h00000000; // Write data
	logic [3:0] wstrb = 4'h1; // Only lane 0 matters
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Master side
	logic awready, wready, bvalid, arready, rvalid, addr_match; // Slave side
	logic [1:0] bresp, rresp, wr_resp, rd_resp; // Responses and their captures
	logic [31:0] rdata, rd_data; // Read data and capture
	twr_evt_s step_evt; // Engine step events
	twr_bit_s rx_bit; // Engine bits
	twr_adr_s addr_byte; // Engine address bytes
	twr_eng_s eng; // Controls to the engine
	int n_errors = 0, n_tests = 0, n_match = 0, n_resume = 0, cyc = 0, last_tick = 0, tick_gap = 0;
	logic [1:0] ps; // Prescale used by a row
	int per, r0; // Expected tick period, counter snapshot
	// Every documented status code except idle 0xF8, one row each
	logic [7:0] rows [26] = '{C_BUS_ERR, C_START, C_RSTART, C_MT_SLA_ACK, C_MT_SLA_NACK, C_MT_DAT_ACK,
		C_MT_DAT_NACK, C_ARB_LOST, C_MR_SLA_ACK, C_MR_SLA_NACK, C_MR_DAT_ACK, C_MR_DAT_NACK, C_SR_SLA,
		C_SR_SLA_ARB, C_SR_GC, C_SR_GC_ARB, C_SR_DAT_ACK, C_SR_DAT_NACK, C_GC_DAT_ACK, C_GC_DAT_NACK,
		C_SR_STOP, C_ST_SLA, C_ST_SLA_ARB, C_ST_DAT_ACK, C_ST_DAT_NACK, C_ST_LAST_ACK};
	////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	always #20 aclk = ~aclk;
	twr_regs #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.step_evt(step_evt), .rx_bit(rx_bit), .addr_byte(addr_byte), .master_active(master_active),
		.eng(eng), .addr_match(addr_match));
	twr_eng_model i_eng (.aclk(aclk), .step_evt(step_evt), .rx_bit(rx_bit), .addr_byte(addr_byte));
	// Pulse counters and tick spacing; pulses are one cycle, so counting them catches a stuck one
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (addr_match === 1'b1) n_match <= n_match + 1;
		if (eng.resume === 1'b1) n_resume <= n_resume + 1;
		if (eng.bit_tick === 1'b1) begin
			tick_gap <= cyc - last_tick;
			last_tick <= cyc;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Write: both halves offered together, each dropped when taken; ready is sampled mid-cycle
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw_ok, w_ok, aw_done, w_done, b_ok;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge aclk);
			aw_ok = awready;
			w_ok = wready;
			@(posedge aclk);
			if (aw_ok && !aw_done) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (w_ok && !w_done) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			b_ok = bvalid;
			wr_resp = bresp;
			@(posedge aclk);
		end while (!b_ok);
		bready <= 1'b0;
	endtask
	// Read: address held until taken, rready held until data arrives
	task automatic rd(input logic [11:0] a);
		logic ok;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ok = arready;
			@(posedge aclk);
		end while (!ok);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ok = rvalid;
			rd_data = rdata;
			rd_resp = rresp;
			@(posedge aclk);
		end while (!ok);
		rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input string name);
		rd(a);
		chk(name, rd_data, {24'h000000, exp});
	endtask
	// Address byte offered to the comparator, then the match pulses are counted
	task automatic adrchk(input logic [7:0] b, input int exp);
		r0 = n_match;
		i_eng.adr(b);
		repeat (3) @(posedge aclk);
		chk("address match count", 32'(n_match - r0), 32'(exp));
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdchk(A_STAT, C_IDLE, "status at reset");
		rdchk(A_DATA, RST_DATA, "data at reset");
		rdchk(A_MASK, 8'h00, "mask at reset");
		rd(12'h000);
		chk("unmapped read resp", 32'(rd_resp), 32'(RESP_SLVERR));
		// Row loop: every code, prescale cycling, reserved bit and code bits written high
		for (int k = 0; k < 26; k++) begin
			ps = 2'(k);
			wr(A_STAT, 8'hFC | 8'(ps));
			i_eng.step(rows[k]);
			rdchk(A_STAT, rows[k] | 8'(ps), "status code");
			wr(A_CTRL, 8'h80);
			rdchk(A_STAT, C_IDLE | 8'(ps), "status after clear");
		end
		// A second step while the flag stands leaves the code alone; unknown codes read as bus error
		i_eng.step(C_START);
		@(posedge aclk);
		i_eng.step(C_ARB_LOST);
		rdchk(A_STAT, C_START | 8'h01, "code held");
		repeat (2) @(posedge aclk);
		chk("clock held low", eng.scl_hold, 1);
		wr(A_CTRL, 8'h00);
		chk("clock still held", eng.scl_hold, 1);
		r0 = n_resume;
		wr(A_CTRL, 8'h80);
		repeat (2) @(posedge aclk);
		chk("clock released", eng.scl_hold, 0);
		chk("resume pulses", 32'(n_resume - r0), 1);
		i_eng.step(8'hD0);
		rdchk(A_STAT, C_BUS_ERR | 8'h01, "unknown code");
		// A clear that meets a new step in one cycle keeps the flag and takes the new code
		r0 = n_resume;
		fork
			wr(A_CTRL, 8'h80);
			begin
				@(posedge aclk);
				i_eng.step(C_SR_STOP);
			end
		join
		repeat (2) @(posedge aclk);
		rdchk(A_STAT, C_SR_STOP | 8'h01, "step beats clear");
		chk("no resume on collision", 32'(n_resume - r0), 0);
		wr(A_CTRL, 8'h80);
		// Data byte: refused while idle, shifts while idle, frozen and writable while flagged
		wr(A_DATA, 8'h5A);
		rdchk(A_DATA, 8'hFF, "data write refused");
		i_eng.shift(8'hA5);
		rdchk(A_DATA, 8'hA5, "data shifted in");
		i_eng.step(C_MR_DAT_ACK);
		i_eng.shift(8'h3C);
		rdchk(A_DATA, 8'hA5, "data frozen");
		wr(A_DATA, 8'h5A);
		rdchk(A_DATA, 8'h5A, "data written");
		chk("byte to engine", eng.tx_byte, 8'h5A);
		wr(A_CTRL, 8'hC0);
		chk("ack enable", eng.ack_en, 1);
		rdchk(A_CTRL, 8'h40, "control readback");
		wr(A_CTRL, 8'h00);
		// Address comparator with mask and general call
		wr(A_ADDR, 8'h54);
		wr(A_MASK, 8'h03);
		rdchk(A_MASK, 8'h02, "mask reserved bit");
		adrchk(8'h55, 1);
		adrchk(8'h57, 1);
		adrchk(8'h5D, 0);
		adrchk(8'h00, 0);
		wr(A_ADDR, 8'h55);
		adrchk(8'h00, 1);
		wr(A_MASK, 8'h00);
		adrchk(8'h57, 0);
		wstrb <= 4'h0;
		wr(A_ADDR, 8'h00);
		wstrb <= 4'h1;
		rdchk(A_ADDR, 8'h55, "lane 0 strobe off");
		// Bit-rate period for each prescale value
		wr(A_RATE, 8'h01);
		chk("mapped write resp", 32'(wr_resp), 32'(RESP_OKAY));
		rdchk(A_RATE, 8'h01, "rate readback");
		chk("mapped read resp", 32'(rd_resp), 32'(RESP_OKAY));
		wr(12'h000, 8'h01);
		chk("unmapped write resp", 32'(wr_resp), 32'(RESP_SLVERR));
		for (int p = 0; p < 4; p++) begin
			wr(A_STAT, 8'(p));
			per = int'(RATE_BASE) + 2 * (4 ** p);
			master_active <= 1'b1;
			repeat (3 * per + 4) @(posedge aclk);
			chk("tick period", 32'(tick_gap), 32'(per));
			master_active <= 1'b0;
			@(posedge aclk);
		end
		// Reset in mid-run restores the reset values
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdchk(A_STAT, C_IDLE, "status after reset");
		rdchk(A_DATA, RST_DATA, "data after reset");
		tally_and_finish;
	end
	// Watchdog: the sequence needs about 1200 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		$display("Watchdog expired");
		tally_and_finish;
	end
endmodule
